//--- verilog/acquisition_sequencer.sv
// acquisition sequencer: pacing, sample counting, trigger gating, scan memory, result buffer
`timescale 1ns/1ps
`include "acq_seq_map.svh"

// What this block does
// - sample interval is a 16-bit down counter on internal or external timebase
// - at zero it gives one low conversion pulse, reloads, repeats until halt
// - conversions closer than 10 us set an overrun flag
// - external pulses ignored before trigger and after the sequence ends
// - sample counter is 16-bit, or two cascaded halves forming 32 bits
// - sample counter drops once per posttrigger conversion, ends acquisition at zero
// - sample counter also counts externally paced conversions
// - single-channel settings latched before start hold for whole acquisition
// - start by software command or low pulse on ext_trigger_n
// - posttrigger: conversions only while in progress, counting from trigger
// - end of sequence gives a completion signal
// - pretrigger: first trigger converts uncounted, second starts counting
// - only posttrigger count is programmed; pretrigger count follows timing
// - pretrigger counting waits for its gate; timer gated the same way in both modes
// - 512-word scan memory: channel, gain, mode, range, sync, forward, end bits
// - selected memory word drives the analog path while selected
// - scan pulse derived from the conversion request, under internal or external pacing, once per conversion
// - pointer advances every scan pulse or every N pulses via divider
// - continuous scan loops the list without pause until count ends
// - scan pulse rising edge marks input acquired, mux may switch
// - results go to 512-word buffer; storing past 512 flags overflow
module acquisition_sequencer
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [3:0]            reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic [15:0]                reg_rdata,
   input  wire logic                  ext_convert_n,
   input  wire logic                  ext_trigger_n,
   input  wire logic                  ext_timebase,
   input  wire logic                  conv_valid,
   input  wire logic [15:0]           conv_data,
   output logic                       convert_n,
   output logic                       scan_pulse_out,
   output logic                       acq_in_progress,
   output logic                       result_push_n,
   output logic                       seq_done,
   output acq_seq_pkg::cfg_word_t     analog_cfg
);

   localparam int MIN_CYC = `MIN_CONV_CYC;

   acq_seq_pkg::acq_state_t state_ff;
   acq_seq_pkg::ctrl_t      ctrl_ff;
   acq_seq_pkg::cfg_word_t  cfg_mem [`CFG_DEPTH];
   acq_seq_pkg::cfg_word_t  single_cfg_ff;
   acq_seq_pkg::cfg_word_t  single_hold_ff;
   acq_seq_pkg::cfg_word_t  analog_cfg_ff;
   acq_seq_pkg::cfg_word_t  cur_word;
   logic [15:0]             res_mem [`RES_DEPTH];

   logic [15:0] interval_ff;
   logic [15:0] timer_ff;
   logic [15:0] tbase_ff;
   logic [15:0] presc_ff;
   logic [15:0] count_lo_ff;
   logic [15:0] count_hi_ff;
   logic [31:0] sample_ff;
   logic [15:0] divide_ff;
   logic [15:0] div_cnt_ff;
   logic [8:0]  cfg_addr_ff;
   logic [8:0]  ptr_ff;
   logic [8:0]  wr_ptr_ff;
   logic [8:0]  rd_ptr_ff;
   logic [9:0]  level_ff;
   logic [15:0] gap_ff;
   logic        seen_ff;
   logic        ext_conv_prev_ff;
   logic        ext_trig_prev_ff;
   logic        ext_tb_prev_ff;
   logic        done_flag_ff;
   logic        overrun_ff;
   logic        overflow_ff;
   logic        convert_n_ff;
   logic        scan_pulse_ff;
   logic        acq_ff;
   logic        push_n_ff;
   logic        seq_done_ff;
   logic [15:0] rdata_ff;

   logic cmd_wr;
   logic arm_cmd;
   logic abort_cmd;
   logic clear_cmd;
   logic trig;
   logic gate;
   logic tick;
   logic conv_fall;
   logic conv_req;
   logic last_conv;
   logic advance;
   logic full;
   logic empty;
   logic push;
   logic pop;

   // next scan location: back to the top after an end-of-list word or the last slot
   function automatic logic [8:0] next_loc(input logic [8:0] p, input logic eos);
      next_loc = (eos || p == 9'h1FF) ? 9'h000 : p + 9'h001;
   endfunction : next_loc

   assign cmd_wr    = reg_wr && reg_addr == `REG_CMD;
   assign arm_cmd   = cmd_wr && reg_wdata[`CMD_ARM];
   assign abort_cmd = cmd_wr && reg_wdata[`CMD_ABORT];
   assign clear_cmd = cmd_wr && reg_wdata[`CMD_CLEAR];

   // software trigger, or a falling edge on the external trigger when enabled
   assign trig = (cmd_wr && reg_wdata[`CMD_TRIGGER])
              || (ctrl_ff.ext_trig_en && ext_trig_prev_ff && !ext_trigger_n);

   assign gate = state_ff == acq_seq_pkg::ST_PRE || state_ff == acq_seq_pkg::ST_POST;

   // internal prescaler or rising edge of the external timebase
   assign tick = ctrl_ff.ext_clk_sel ? (!ext_tb_prev_ff && ext_timebase)
                                     : (presc_ff == 16'h0000);

   // falling edge on ext_convert_n; conv_req ignores it unless ext_pace selects external pacing
   assign conv_fall = ext_conv_prev_ff && !ext_convert_n;

   // conversions only inside the gate, whichever source paces them
   assign conv_req = gate && (ctrl_ff.ext_pace ? conv_fall
                                               : (tick && timer_ff == 16'h0000));

   assign last_conv = state_ff == acq_seq_pkg::ST_POST && conv_req
                   && sample_ff <= 32'h0000_0001;

   assign cur_word = cfg_mem[ptr_ff];
   assign advance  = conv_req && ctrl_ff.scan_en
                  && (!ctrl_ff.div_en || div_cnt_ff + 16'h0001 >= divide_ff);

   assign full  = level_ff == 10'(`RES_DEPTH);
   assign empty = level_ff == 10'h000;
   assign push  = conv_valid && !full;
   assign pop   = reg_rd && reg_addr == `REG_RESULT && !empty;

   // sequence state
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_ff <= acq_seq_pkg::ST_IDLE;
      else if (abort_cmd)
         state_ff <= acq_seq_pkg::ST_IDLE;
      else
      begin
         unique case (state_ff)
            acq_seq_pkg::ST_IDLE:
               if (arm_cmd)
                  state_ff <= acq_seq_pkg::ST_ARMED;
            acq_seq_pkg::ST_ARMED:
               if (trig)
                  state_ff <= ctrl_ff.pretrig ? acq_seq_pkg::ST_PRE
                                              : acq_seq_pkg::ST_POST;
            acq_seq_pkg::ST_PRE:
               if (trig)
                  state_ff <= acq_seq_pkg::ST_POST;
            acq_seq_pkg::ST_POST:
               if (last_conv)
                  state_ff <= acq_seq_pkg::ST_IDLE;
         endcase
      end
   end

   // register writes
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_ff       <= `CTRL_RESET;
         interval_ff   <= `INTERVAL_RESET;
         tbase_ff      <= `TIMEBASE_RESET;
         count_lo_ff   <= 16'h0000;
         count_hi_ff   <= 16'h0000;
         divide_ff     <= `DIVIDE_RESET;
         single_cfg_ff <= 16'h0000;
         cfg_addr_ff   <= 9'h000;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `REG_CTRL:       ctrl_ff       <= reg_wdata & `CTRL_MASK;
            `REG_INTERVAL:   interval_ff   <= reg_wdata;
            `REG_TIMEBASE:   tbase_ff      <= reg_wdata;
            `REG_COUNT_LO:   count_lo_ff   <= reg_wdata;
            `REG_COUNT_HI:   count_hi_ff   <= reg_wdata;
            `REG_DIVIDE:     divide_ff     <= reg_wdata;
            `REG_SINGLE_CFG: single_cfg_ff <= reg_wdata & `CFG_MASK;
            `REG_CFG_ADDR:   cfg_addr_ff   <= reg_wdata[8:0];
            `REG_CFG_DATA:   cfg_addr_ff   <= cfg_addr_ff + 9'h001;
            default:         ;
         endcase
      end
   end

   // scan memory fill; no reset on the array
   always_ff @(posedge clk)
   begin
      if (reg_wr && reg_addr == `REG_CFG_DATA)
         cfg_mem[cfg_addr_ff] <= reg_wdata & `CFG_MASK;
   end

   // timebase prescaler, free running
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         presc_ff <= 16'h0000;
      else if (presc_ff == 16'h0000)
         presc_ff <= tbase_ff;
      else
         presc_ff <= presc_ff - 16'h0001;
   end

   // sample-interval down counter
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_ff <= `INTERVAL_RESET;
      else if (!gate)
         timer_ff <= interval_ff;
      else if (tick)
         timer_ff <= (timer_ff == 16'h0000) ? interval_ff
                                            : timer_ff - 16'h0001;
   end

   // sample counter, loaded on arm; 16-bit unless cascaded
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sample_ff <= 32'h0000_0000;
      else if (state_ff == acq_seq_pkg::ST_IDLE && arm_cmd)
         sample_ff <= {ctrl_ff.cascade ? count_hi_ff : 16'h0000, count_lo_ff};
      else if (state_ff == acq_seq_pkg::ST_POST && conv_req && !last_conv)
         sample_ff <= sample_ff - 32'h0000_0001;
   end

   // spacing between conversions, for overrun detection
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_ff  <= 16'h0000;
         seen_ff <= 1'b0;
      end
      else if (arm_cmd)
      begin
         gap_ff  <= 16'h0000;
         seen_ff <= 1'b0;
      end
      else if (conv_req)
      begin
         gap_ff  <= 16'h0001;
         seen_ff <= 1'b1;
      end
      else if (gap_ff < 16'(MIN_CYC))
         gap_ff <= gap_ff + 16'h0001;
   end

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         done_flag_ff <= 1'b0;
         overrun_ff   <= 1'b0;
         overflow_ff  <= 1'b0;
      end
      else
      begin
         done_flag_ff <= last_conv || (done_flag_ff && !clear_cmd);
         overrun_ff   <= (conv_req && seen_ff && gap_ff < 16'(MIN_CYC))
                      || (overrun_ff && !clear_cmd);
         overflow_ff  <= (conv_valid && full) || (overflow_ff && !clear_cmd);
      end
   end

   // scan pointer and divider
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ptr_ff     <= 9'h000;
         div_cnt_ff <= 16'h0000;
      end
      else if (state_ff == acq_seq_pkg::ST_IDLE && arm_cmd)
      begin
         ptr_ff     <= 9'h000;
         div_cnt_ff <= 16'h0000;
      end
      else if (advance)
      begin
         ptr_ff     <= next_loc(ptr_ff, cur_word.eos);
         div_cnt_ff <= 16'h0000;
      end
      else if (conv_req && ctrl_ff.scan_en)
         div_cnt_ff <= div_cnt_ff + 16'h0001;
   end

   // analog path settings; single-channel word frozen once armed
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         single_hold_ff <= 16'h0000;
         analog_cfg_ff  <= 16'h0000;
      end
      else
      begin
         if (state_ff == acq_seq_pkg::ST_IDLE)
            single_hold_ff <= single_cfg_ff;
         analog_cfg_ff <= ctrl_ff.scan_en ? cur_word : single_hold_ff;
      end
   end

   // pin-side pulses, all registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_conv_prev_ff <= 1'b1;
         ext_trig_prev_ff <= 1'b1;
         ext_tb_prev_ff   <= 1'b0;
         convert_n_ff     <= 1'b1;
         scan_pulse_ff    <= 1'b0;
         acq_ff           <= 1'b0;
         seq_done_ff      <= 1'b0;
      end
      else
      begin
         ext_conv_prev_ff <= ext_convert_n;
         ext_trig_prev_ff <= ext_trigger_n;
         ext_tb_prev_ff   <= ext_timebase;
         convert_n_ff     <= !conv_req;
         // rises with the conversion start, after the sample is taken
         scan_pulse_ff    <= conv_req && ctrl_ff.scan_en;
         acq_ff           <= gate;
         seq_done_ff      <= last_conv;
      end
   end

   // result buffer; a full buffer drops the new value
   always_ff @(posedge clk)
   begin
      if (push)
         res_mem[wr_ptr_ff] <= conv_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr_ff <= 9'h000;
         rd_ptr_ff <= 9'h000;
         level_ff  <= 10'h000;
         push_n_ff <= 1'b1;
      end
      else
      begin
         push_n_ff <= !push;
         if (push)
            wr_ptr_ff <= wr_ptr_ff + 9'h001;
         if (pop)
            rd_ptr_ff <= rd_ptr_ff + 9'h001;
         if (push && !pop)
            level_ff <= level_ff + 10'h001;
         else if (pop && !push)
            level_ff <= level_ff - 10'h001;
      end
   end

   // read data, one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_ff <= 16'h0000;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `REG_CTRL:       rdata_ff <= ctrl_ff;
            `REG_INTERVAL:   rdata_ff <= interval_ff;
            `REG_TIMEBASE:   rdata_ff <= tbase_ff;
            `REG_COUNT_LO:   rdata_ff <= count_lo_ff;
            `REG_COUNT_HI:   rdata_ff <= count_hi_ff;
            `REG_DIVIDE:     rdata_ff <= divide_ff;
            `REG_SINGLE_CFG: rdata_ff <= single_cfg_ff;
            `REG_CFG_ADDR:   rdata_ff <= {7'h00, cfg_addr_ff};
            `REG_CFG_DATA:   rdata_ff <= cfg_mem[cfg_addr_ff];
            `REG_STATUS:     rdata_ff <= {8'h00, full, empty,
                                          state_ff == acq_seq_pkg::ST_PRE,
                                          state_ff == acq_seq_pkg::ST_ARMED,
                                          overflow_ff, overrun_ff, done_flag_ff, gate};
            `REG_RESULT:     rdata_ff <= empty ? 16'h0000 : res_mem[rd_ptr_ff];
            `REG_LEVEL:      rdata_ff <= {6'h00, level_ff};
            default:         rdata_ff <= 16'h0000;
         endcase
      end
      else
         rdata_ff <= 16'h0000;
   end

   assign reg_rdata       = rdata_ff;
   assign convert_n       = convert_n_ff;
   assign scan_pulse_out  = scan_pulse_ff;
   assign acq_in_progress = acq_ff;
   assign result_push_n   = push_n_ff;
   assign seq_done        = seq_done_ff;
   assign analog_cfg      = analog_cfg_ff;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   localparam int TRIG_MIN = 1;
   localparam int TRIG_MAX = 2;

   sequence s_advance_at_end;
      advance && cur_word.eos;
   endsequence

   sequence s_armed_trigger;
      state_ff == acq_seq_pkg::ST_ARMED && trig && !abort_cmd;
   endsequence

   a_conv_in_gate: assert property (!convert_n |-> acq_in_progress)
      else $error("conversion pulse outside acquisition");
   a_scan_with_conv: assert property (scan_pulse_out |-> !convert_n)
      else $error("scan pulse without conversion");
   a_no_conv_idle: assert property (!gate |-> ##1 convert_n)
      else $error("conversion while inhibited");
   a_overrun_catch: assert property
      (conv_req && seen_ff && gap_ff < 16'(MIN_CYC) |=> overrun_ff)
      else $error("close conversions not flagged");
   a_push_strobe: assert property (push |=> !result_push_n && $past(level_ff) != level_ff
                                   || $past(pop))
      else $error("result not stored");
   a_overflow_flag: assert property (conv_valid && full |=> overflow_ff)
      else $error("overflow not flagged");
   a_done_ends_acq: assert property (seq_done |=> !acq_in_progress && state_ff ==
                                     acq_seq_pkg::ST_IDLE)
      else $error("acquisition runs past its end");
   a_post_decrement: assert property
      (state_ff == acq_seq_pkg::ST_POST && conv_req && !last_conv && !abort_cmd
       |=> sample_ff == $past(sample_ff) - 32'h0000_0001)
      else $error("sample count not decremented");
   a_pre_no_count: assert property
      (state_ff == acq_seq_pkg::ST_PRE |=> $stable(sample_ff))
      else $error("pretrigger conversion counted");
   a_list_wrap: assert property (s_advance_at_end |=> ptr_ff == 9'h000)
      else $error("pointer did not wrap after end of list");
   a_arm_ptr_home: assert property
      (state_ff == acq_seq_pkg::ST_IDLE && arm_cmd && !abort_cmd |=> ptr_ff == 9'h000)
      else $error("pointer not reset on arm");
   a_trigger_starts: assert property
      (s_armed_trigger |-> ##[TRIG_MIN:TRIG_MAX] acq_in_progress)
      else $error("trigger did not start acquisition");
   a_single_frozen: assert property
      ((state_ff != acq_seq_pkg::ST_IDLE && !ctrl_ff.scan_en)[*3] |-> $stable(analog_cfg))
      else $error("single-channel settings changed mid acquisition");

endmodule : acquisition_sequencer

//--- verilog/acq_seq_map.svh
// offsets, field positions, reset values and timing figures of the acquisition sequencer
`ifndef ACQ_SEQ_MAP_SVH
`define ACQ_SEQ_MAP_SVH

// register indices on the plain register port
`define REG_CTRL        4'h0
`define REG_CMD         4'h1
`define REG_INTERVAL    4'h2
`define REG_COUNT_LO    4'h3
`define REG_COUNT_HI    4'h4
`define REG_DIVIDE      4'h5
`define REG_TIMEBASE    4'h6
`define REG_SINGLE_CFG  4'h7
`define REG_CFG_ADDR    4'h8
`define REG_CFG_DATA    4'h9
`define REG_STATUS      4'hA
`define REG_RESULT      4'hB
`define REG_LEVEL       4'hC

// command bits
`define CMD_ARM         0
`define CMD_TRIGGER     1
`define CMD_ABORT       2
`define CMD_CLEAR       3

// status bits
`define ST_BUSY         0
`define ST_DONE         1
`define ST_OVERRUN      2
`define ST_OVERFLOW     3
`define ST_ARMED        4
`define ST_PRE          5
`define ST_EMPTY        6
`define ST_FULL         7

// reset values and masks
`define CTRL_RESET      16'h0000
`define CTRL_MASK       16'h007F
`define INTERVAL_RESET  16'h0001
`define TIMEBASE_RESET  16'h0000
`define DIVIDE_RESET    16'h0001
`define CFG_MASK        16'h0FFF

// sizes
`define CFG_DEPTH       512
`define RES_DEPTH       512

// shortest legal conversion interval
`define MIN_CONV_NS     10000
`define CLK_PERIOD_NS   8
`define MIN_CONV_CYC    ((`MIN_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- verilog/acq_seq_pkg.sv
// types shared by the acquisition sequencer
package acq_seq_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_PRE   = 2'b10,
      ST_POST  = 2'b11
   } acq_state_t;

   typedef struct packed
   {
      logic [8:0] rsvd;
      logic       ext_clk_sel;
      logic       div_en;
      logic       cascade;
      logic       ext_trig_en;
      logic       ext_pace;
      logic       pretrig;
      logic       scan_en;
   } ctrl_t;

   typedef struct packed
   {
      logic [3:0] rsvd;
      logic       eos;
      logic       serial_fwd;
      logic       scan_sync;
      logic       bipolar;
      logic       diff;
      logic [2:0] gain;
      logic [3:0] channel;
   } cfg_word_t;

endpackage : acq_seq_pkg

//--- verif/conv_front_model.sv
// converter front end model: answers a conversion start with a result LAT cycles later, unless a new start comes first
`timescale 1ns/1ps
module conv_front_model
#(
   parameter int LAT = 4
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        convert_n,
   output logic             conv_valid,
   output logic [15:0]      conv_data
);
   int          wait_ff;
   logic [15:0] seq_ff;
   // idle data toggles so a stale word never passes for a result
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_ff    <= 0;
         seq_ff     <= 16'h0000;
         conv_valid <= 1'b0;
         conv_data  <= 16'h0000;
      end
      else
      begin
         conv_valid <= 1'b0;
         conv_data  <= ~conv_data;
         if (!convert_n)
            wait_ff <= LAT;
         else if (wait_ff != 0)
            wait_ff <= wait_ff - 1;
         if (convert_n && wait_ff == 1)
         begin
            conv_valid <= 1'b1;
            conv_data  <= seq_ff;
            seq_ff     <= seq_ff + 16'h0001;
         end
      end
   end
endmodule : conv_front_model

//--- verif/acquisition_sequencer_bench.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`include "acq_seq_map.svh"
module acquisition_sequencer_bench;
   logic                   clk, rst_n, reg_wr, reg_rd, ext_convert_n, ext_trigger_n;
   logic                   conv_valid, convert_n, scan_pulse_out, acq_in_progress;
   logic                   result_push_n, seq_done;
   logic [3:0]             reg_addr;
   logic [15:0]            reg_wdata, reg_rdata, conv_data, rd_val;
   acq_seq_pkg::cfg_word_t analog_cfg, cfg_seen;
   logic                   ext_timebase = 1'b0;
   logic [3:0]             chan_q[$];
   int                     mismatches = 0, n_compared = 0, cyc = 0, last_c = 0, gap = 0;
   int                     n_conv = 0, n_scan = 0, n_done = 0, n_push = 0;

   acquisition_sequencer uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_convert_n(ext_convert_n), .ext_trigger_n(ext_trigger_n),
      .ext_timebase(ext_timebase),
      .conv_valid(conv_valid), .conv_data(conv_data), .convert_n(convert_n),
      .scan_pulse_out(scan_pulse_out), .acq_in_progress(acq_in_progress),
      .result_push_n(result_push_n), .seq_done(seq_done), .analog_cfg(analog_cfg));
   conv_front_model #(.LAT(4)) front (.clk(clk), .rst_n(rst_n), .convert_n(convert_n),
      .conv_valid(conv_valid), .conv_data(conv_data));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // external timebase: one rising edge every two clocks
   always @(posedge clk)
      ext_timebase <= !ext_timebase;

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_n(input int got, input int exp);
      chk(16'(got), 16'(exp));
   endtask : chk_n

   // output watcher; every conversion strobe is one low cycle
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         $display("unexpected at %0t: run did not end in time", $time);
         finish_test();
      end
      if (rst_n && convert_n === 1'b0)
      begin
         n_conv++;
         gap = cyc - last_c;
         last_c = cyc;
         chan_q.push_back(analog_cfg.channel);
         cfg_seen = analog_cfg;
      end
      if (rst_n && scan_pulse_out === 1'b1)
      begin
         n_scan++;
         chk({15'h0000, convert_n}, 16'h0000);
      end
      if (seq_done === 1'b1)
         n_done++;
      if (result_push_n === 1'b0)
         n_push++;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask : rd

   // one low cycle on trigger or conversion input, then idle high
   task automatic pulse(input bit trig, input int gap_c);
      @(posedge clk);
      if (trig)
         ext_trigger_n <= 1'b0;
      else
         ext_convert_n <= 1'b0;
      @(posedge clk);
      ext_trigger_n <= 1'b1;
      ext_convert_n <= 1'b1;
      repeat (gap_c) @(posedge clk);
      #1;
   endtask : pulse

   task automatic clr();
      {n_conv, n_scan, n_done, n_push} = 0;
      chan_q.delete();
   endtask : clr

   task automatic t_regs();
      rd(`REG_CTRL);
      chk(rd_val, `CTRL_RESET);
      rd(`REG_INTERVAL);
      chk(rd_val, `INTERVAL_RESET);
      rd(`REG_DIVIDE);
      chk(rd_val, `DIVIDE_RESET);
      wr(4'hD, 16'hFFFF);
      rd(4'hD);
      chk(rd_val, 16'h0000);
   endtask : t_regs

   task automatic t_post();
      wr(`REG_CTRL, 16'h000C);
      wr(`REG_COUNT_LO, 16'h0002);
      wr(`REG_SINGLE_CFG, 16'h0123);
      wr(`REG_CMD, 16'h0001);
      wr(`REG_SINGLE_CFG, 16'h0456);
      clr();
      pulse(0, 1300);
      chk_n(n_conv, 0);
      pulse(1, 4);
      chk({15'h0000, acq_in_progress}, 16'h0001);
      pulse(0, 1300);
      pulse(0, 8);
      chk_n(n_conv, 2);
      chk_n(n_done, 1);
      chk_n(n_scan, 0);
      chk({15'h0000, acq_in_progress}, 16'h0000);
      chk(cfg_seen, 16'h0123);
      chk_n(n_push, 2);
      pulse(0, 8);
      chk_n(n_conv, 2);
      rd(`REG_STATUS);
      chk(rd_val & 16'h0006, 16'h0002);
      rd(`REG_LEVEL);
      chk(rd_val, 16'h0002);
      rd(`REG_RESULT);
      chk(rd_val, 16'h0000);
      rd(`REG_RESULT);
      chk(rd_val, 16'h0001);
   endtask : t_post

   // internal prescaler, or external timebase with cascaded count and abort
   task automatic t_int(input logic [15:0] ctrl, input logic [15:0] tb);
      wr(`REG_CMD, 16'h0008);
      wr(`REG_CTRL, ctrl);
      wr(`REG_INTERVAL, 16'h0003);
      wr(`REG_TIMEBASE, tb);
      wr(`REG_COUNT_HI, 16'h0001);
      wr(`REG_COUNT_LO, 16'h0003);
      wr(`REG_CMD, 16'h0001);
      clr();
      wr(`REG_CMD, 16'h0002);
      repeat (60) @(posedge clk);
      #1;
      if (ctrl[4])
         chk_n(n_done == 0 && n_conv >= 5, 1);
      else
         chk_n(n_conv, 3);
      chk_n(gap, 8);
      rd(`REG_STATUS);
      chk(rd_val & 16'h0004, 16'h0004);
      wr(`REG_CMD, 16'h0004);
      wr(`REG_TIMEBASE, 16'h0000);
   endtask : t_int

   task automatic t_scan(input logic [15:0] ctrl, input int dv, input int n);
      wr(`REG_CTRL, ctrl);
      wr(`REG_DIVIDE, 16'(dv));
      wr(`REG_COUNT_LO, 16'(n));
      wr(`REG_CMD, 16'h0001);
      clr();
      wr(`REG_CMD, 16'h0002);
      repeat (n) pulse(0, 4);
      chk_n(n_scan, n);
      for (int i = 0; i < n; i++)
         chk({12'h000, chan_q[i]}, 16'(5 + (i / dv) % 3));
   endtask : t_scan

   task automatic t_pre();
      wr(`REG_CTRL, 16'h0006);
      wr(`REG_COUNT_LO, 16'h0002);
      wr(`REG_CMD, 16'h0001);
      clr();
      wr(`REG_CMD, 16'h0002);
      repeat (3) pulse(0, 4);
      chk_n(n_done, 0);
      rd(`REG_STATUS);
      chk(rd_val & 16'h0020, 16'h0020);
      wr(`REG_CMD, 16'h0002);
      repeat (2) pulse(0, 4);
      chk_n(n_conv, 5);
      chk_n(n_done, 1);
      repeat (4) @(posedge clk);
      chk_n(n_push, 5);
   endtask : t_pre

   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {ext_convert_n, ext_trigger_n} = 2'b11;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_post();
      t_int(16'h0000, 16'h0001);
      t_int(16'h0050, 16'h0000);
      wr(`REG_CFG_ADDR, 16'h0000);
      wr(`REG_CFG_DATA, 16'h0005);
      wr(`REG_CFG_DATA, 16'h0006);
      wr(`REG_CFG_DATA, 16'h0807);
      t_scan(16'h0005, 1, 4);
      t_scan(16'h0025, 2, 5);
      t_pre();
      finish_test();
   end
endmodule : acquisition_sequencer_bench
